// ==== rtl/odt_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none

module odt_ctrl
  import odt_pkg::*;
#(
  parameter int DEPTH  = 40,
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              odt_pin,
  input  wire logic              cke_pin,
  input  wire logic              wr_cmd_pin,
  input  wire logic              bc4_pin,
  input  wire logic              banks_idle,
  input  wire logic              self_refresh,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  output var  logic              term_en,
  output var  logic              term_wr,
  output var  logic [2:0]        term_code
);

  initial begin
    if (DEPTH < LAT_MAX + CWN8_EXTRA + 1) begin
      $error("DEPTH too small for the longest latency");
    end
    if (ADDR_W < 8) begin
      $error("ADDR_W must be at least 8");
    end
    if (ASYNC_MAX_CYC != 1 || ASYNC_MIN_CYC != 1) begin
      $error("Asynchronous path is one flop and needs a one-cycle window");
    end
    if (DEPTH < 2) begin
      $error("DEPTH must be at least 2");
    end
    if (CWN4_EXTRA >= CWN8_EXTRA) begin
      $error("Short-burst return must come before long-burst return");
    end
    if (CWN4_EXTRA < 1) begin
      $error("Short-burst return needs at least one cycle");
    end
    if (ODTL_OFFSET < 0) begin
      $error("Latency offset must not be negative");
    end
    if (TAONPD_MIN_PS > TAONPD_MAX_PS) begin
      $error("Asynchronous window is empty");
    end
    if (TCK_PS <= 0) begin
      $error("Clock period must be positive");
    end
  end

  typedef struct packed {
    pins_t             sync1;
    pins_t             sync2;
    logic [DEPTH-1:0]  odt_line;
    logic [DEPTH-1:0]  wr_line;
    logic [DEPTH-1:0]  bc4_line;
    cfg_t              cfg;
    logic              term_en;
    logic              term_wr;
    logic [2:0]        term_code;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } state_t;

  localparam state_t STATE_RST = '{sync1: '0, sync2: '0, odt_line: '0, wr_line: '0,
                                   bc4_line: '0, cfg: CFG_RST, term_en: 1'b0,
                                   term_wr: 1'b0, term_code: 3'h0, prdata: 32'h0,
                                   pready: 1'b0, pslverr: 1'b0};

  state_t cur_ff;
  state_t nxt_cur;

  // Latency bookkeeping
  logic [4:0]  lat_sum;
  logic [4:0]  lat;
  logic        short_lat;
  int          i_tap;
  int          i_on;
  int          i_c4;
  int          i_c8;

  // Mode decode
  logic        pd_mode;
  logic        async_mode;
  logic        odt_allowed;
  logic        dyn_en;
  logic        wr_now;
  logic        bc4_now;

  // Delay line taps
  logic        odt_tap;
  logic        cnw_hit;
  logic        cwn4_hit;
  logic        cwn8_hit;

  // Register bus decode
  logic        setup_ph;
  logic        access_ph;
  logic        sel_cfg;
  logic        sel_stat;
  logic        mapped;
  logic        refused;
  logic [31:0] cfg_word;
  logic [31:0] stat_word;
  logic [31:0] rd_word;
  cfg_t        cfg_new;

  always_comb begin
    nxt_cur = cur_ff;

    // Two-stage pin synchronisers
    nxt_cur.sync1 = '{bc4: bc4_pin, wr: wr_cmd_pin, cke: cke_pin, odt: odt_pin};
    nxt_cur.sync2 = cur_ff.sync1;

    // Latency from the registering edge, floor of one cycle
    lat_sum   = {1'b0, cur_ff.cfg.cwl} + {1'b0, cur_ff.cfg.al};
    lat       = (lat_sum > 5'h02) ? lat_sum - 5'h02 : 5'h01;
    short_lat = (lat == 5'h01);

    // Sync stage counts as one cycle, output flop as another
    i_tap = int'(lat) - 2;
    i_on  = short_lat ? 0 : i_tap;
    i_c4  = i_tap + CWN4_EXTRA;
    i_c8  = i_tap + CWN8_EXTRA;

    // Mode decode
    pd_mode     = !cur_ff.sync2.cke && banks_idle;
    async_mode  = pd_mode && !cur_ff.cfg.dll_on_pd;
    odt_allowed = (|cur_ff.cfg.rtt_nom) || (|cur_ff.cfg.rtt_wr);
    dyn_en      = |cur_ff.cfg.rtt_wr;
    wr_now      = cur_ff.sync2.wr && cur_ff.sync2.cke;
    bc4_now     = wr_now && cur_ff.sync2.bc4;

    // Delay lines for ODT and write events
    nxt_cur.odt_line = {cur_ff.odt_line[DEPTH-2:0], cur_ff.sync2.odt};
    nxt_cur.wr_line  = {cur_ff.wr_line[DEPTH-2:0], wr_now};
    nxt_cur.bc4_line = {cur_ff.bc4_line[DEPTH-2:0], bc4_now};

    // Shortest latency bypasses the delay line
    odt_tap = short_lat ? cur_ff.sync2.odt : cur_ff.odt_line[i_on];

    // On/off timing, never influenced by write commands; rtt_wr only counts toward odt_allowed
    if (self_refresh || !odt_allowed) begin
      nxt_cur.term_en = 1'b0;
    end else if (async_mode) begin
      nxt_cur.term_en = cur_ff.sync2.odt;
    end else begin
      nxt_cur.term_en = odt_tap;
    end

    cnw_hit  = short_lat ? wr_now : cur_ff.wr_line[i_on];
    cwn4_hit = cur_ff.wr_line[i_c4] && cur_ff.bc4_line[i_c4];
    cwn8_hit = cur_ff.wr_line[i_c8] && !cur_ff.bc4_line[i_c8];

    // Strength select; a new write's switch wins over an old write's return
    if (!dyn_en || async_mode || self_refresh) begin
      nxt_cur.term_wr = 1'b0;
    end else if (cnw_hit) begin
      nxt_cur.term_wr = 1'b1;
    end else if (cwn4_hit || cwn8_hit) begin
      nxt_cur.term_wr = 1'b0;
    end

    nxt_cur.term_code = nxt_cur.term_wr ? {1'b0, cur_ff.cfg.rtt_wr}
                                        : cur_ff.cfg.rtt_nom;

    // APB slave: no wait states, answer prepared in the setup cycle
    setup_ph  = psel && !penable;
    access_ph = psel && penable && cur_ff.pready;
    sel_cfg   = (paddr == ADDR_W'(ADDR_CFG));
    sel_stat  = (paddr == ADDR_W'(ADDR_STAT));
    mapped    = sel_cfg || sel_stat;
    refused   = !mapped || (pwrite && sel_stat);

    // Read words, upper bits read as zero
    cfg_word  = {16'h0000, cur_ff.cfg};
    stat_word = {28'h0000000, dyn_en, async_mode, cur_ff.term_wr, cur_ff.term_en};
    if (!pwrite && sel_cfg) begin
      rd_word = cfg_word;
    end else if (!pwrite && sel_stat) begin
      rd_word = stat_word;
    end else begin
      rd_word = 32'h0;
    end

    // Reserved field never holds written ones
    cfg_new      = cfg_t'(pwdata[15:0]);
    cfg_new.rsvd = 2'h0;

    nxt_cur.pready = setup_ph;
    if (setup_ph) begin
      nxt_cur.pslverr = refused;
      nxt_cur.prdata  = rd_word;
    end else if (access_ph) begin
      nxt_cur.pslverr = 1'b0;
      nxt_cur.prdata  = 32'h0;
      if (pwrite && sel_cfg) begin
        nxt_cur.cfg = cfg_new;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff <= STATE_RST;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign prdata    = cur_ff.prdata;
  assign pready    = cur_ff.pready;
  assign pslverr   = cur_ff.pslverr;
  assign term_en   = cur_ff.term_en;
  assign term_wr   = cur_ff.term_wr;
  assign term_code = cur_ff.term_code;

endmodule : odt_ctrl

`default_nettype wire

// ==== rtl/odt_pkg.sv ====
package odt_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CFG  = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;

  // Reset values of the latency fields
  localparam logic [3:0] CWL_RST = 4'h5;
  localparam logic [3:0] AL_RST  = 4'h0;

  // Latency figures in clock cycles
  localparam int ODTL_OFFSET = 2;
  localparam int CWN4_EXTRA  = 4;
  localparam int CWN8_EXTRA  = 6;
  localparam int LAT_MAX     = 15 + 15 - ODTL_OFFSET;

  // Asynchronous turn-on/off window, in picoseconds
  localparam int TCK_PS        = 8000;
  localparam int TAONPD_MIN_PS = 2000;
  localparam int TAONPD_MAX_PS = 8500;
  localparam int ASYNC_MIN_CYC = (TAONPD_MIN_PS + TCK_PS - 1) / TCK_PS;
  localparam int ASYNC_MAX_CYC = (TAONPD_MAX_PS / TCK_PS < 1) ? 1 : TAONPD_MAX_PS / TCK_PS;

  // Configuration word, bit 0 upward: dll_on_pd, rtt_nom, rtt_wr, reserved, cwl, al
  typedef struct packed {
    logic [3:0] al;
    logic [3:0] cwl;
    logic [1:0] rsvd;
    logic [1:0] rtt_wr;
    logic [2:0] rtt_nom;
    logic       dll_on_pd;
  } cfg_t;

  localparam cfg_t CFG_RST = '{al: AL_RST, cwl: CWL_RST, rsvd: 2'h0,
                               rtt_wr: 2'h0, rtt_nom: 3'h0, dll_on_pd: 1'h0};

  // Pin samples from the controller side
  typedef struct packed {
    logic bc4;
    logic wr;
    logic cke;
    logic odt;
  } pins_t;

endpackage : odt_pkg

// ==== verification/odt_ctrl_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module odt_ctrl_checker
  import odt_pkg::*;
(
  input wire logic        clk, arst_n, odt_pin, cke_pin, wr_cmd_pin, bc4_pin,
  input wire logic        banks_idle, self_refresh, psel, penable, pwrite,
  input wire logic        pready, pslverr, term_en, term_wr,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0]  term_code
);
  cfg_t       c_ff;
  logic [3:0] ok_ff;
  // Settled sync mode at the reset latency
  wire ok = c_ff.cwl == 4'h5 && c_ff.al == 4'h0 && (|c_ff.rtt_nom) && cke_pin && !self_refresh;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      c_ff  <= CFG_RST;
      ok_ff <= 4'h0;
    end else begin
      if (psel && penable && pready && pwrite && paddr == ADDR_CFG) c_ff <= pwdata[15:0];
      ok_ff <= !ok ? 4'h0 : (ok_ff == 4'hf ? ok_ff : ok_ff + 4'h1);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_TERM_LAT: assert property (ok_ff > 4'h6 |-> term_en == $past(odt_pin, 5))
    else $error("term_en off its latency");
  AST_WR_ON: assert property (ok_ff > 4'h6 && (|c_ff.rtt_wr) && $past(wr_cmd_pin, 5) |-> term_wr)
    else $error("write strength not selected");
  AST_WR_CAUSE: assert property (ok_ff > 4'h6 && $rose(term_wr) |-> $past(wr_cmd_pin, 5))
    else $error("write strength without write");
  AST_WR_OFF: assert property (ok_ff > 4'hc && $fell(term_wr) |->
    ($past(wr_cmd_pin, 9) && $past(bc4_pin, 9)) || ($past(wr_cmd_pin, 11) && !$past(bc4_pin, 11)))
    else $error("write strength ended at wrong time");
  AST_DYN_OFF: assert property ((c_ff.rtt_wr == 2'h0) [*2] |-> !term_wr)
    else $error("write strength while disabled");
  AST_SR: assert property (self_refresh [*2] |-> !term_en && !term_wr)
    else $error("termination in self-refresh");
  AST_CODE: assert property (term_en && !term_wr && $stable(c_ff) |-> term_code == c_ff.rtt_nom)
    else $error("wrong nominal code");
  AST_WR_CODE: assert property (term_wr |-> !term_code[2])
    else $error("wrong write code");
  AST_ASYNC: assert property ((!cke_pin && banks_idle && !self_refresh && !c_ff.dll_on_pd
    && (|c_ff.rtt_nom)) [*6] |-> term_en == $past(odt_pin, 3)) else $error("async follow wrong");
  AST_RDY: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer timing");
  AST_ERR: assert property (pready && !(paddr == ADDR_CFG || paddr == ADDR_STAT && !pwrite)
    |-> pslverr) else $error("refused access not flagged");
  cover property ($rose(term_wr));
  cover property (pslverr);
  cover property (!cke_pin && term_en);
endmodule : odt_ctrl_checker
bind odt_ctrl odt_ctrl_checker u_chk (.*);
`default_nettype wire

// ==== verification/odt_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module odt_host_model (
  input  wire logic clk, arst_n, go, wr, bc4, pd,
  output var  logic odt_pin, cke_pin, wr_cmd_pin, bc4_pin, busy
);
  logic [3:0] n_ff;
  assign busy = |n_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      n_ff       <= 4'h0;
      odt_pin    <= 1'b0;
      cke_pin    <= 1'b1;
      wr_cmd_pin <= 1'b0;
      bc4_pin    <= 1'b0;
    end else begin
      wr_cmd_pin <= go && wr && !pd;
      bc4_pin    <= go ? bc4 : ~bc4_pin;
      if (go) begin
        n_ff    <= 4'h9;
        odt_pin <= 1'b1;
        cke_pin <= !pd;
      end else if (n_ff != 4'h0) begin
        n_ff    <= n_ff - 4'h1;
        odt_pin <= n_ff > 4'h1;
      end
    end
  end
endmodule : odt_host_model
`default_nettype wire

// ==== verification/test_dram_dynamic_async_odt.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_dram_dynamic_async_odt;
  import odt_pkg::*;
  logic clk = 0, arst_n = 0, go = 0, wr = 0, bc4 = 0, pd = 0, banks_idle = 0, self_refresh = 0;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, term_en, term_wr, busy;
  logic odt_pin, cke_pin, wr_cmd_pin, bc4_pin, w, b;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [2:0]  term_code;
  logic [32:0] exp_q[$];
  int error_cnt = 0, n_compared = 0, seed = 49381;
  odt_ctrl dut (.*);
  odt_host_model u_host (.*);
  initial forever #4 clk = ~clk;
  task automatic print_verdict;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] apb {pslverr,prdata} exp %h seen %h", exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wt, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int i;
    exp_q.push_back(e);
    @(posedge clk) begin
      psel <= 1'b1; pwrite <= wt; paddr <= a; pwdata <= d;
    end
    @(posedge clk) penable <= 1'b1;
    i = 0;
    do @(posedge clk); while (!pready && ++i < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20) begin
      error_cnt++;
      print_verdict();
    end
  endtask : apb
  // One ODT burst from the host, then a status read in mid-burst
  task automatic burst(input logic wt, input logic bt, input logic p, input logic [31:0] st);
    @(posedge clk) begin
      go <= 1'b1; wr <= wt; bc4 <= bt; pd <= p;
    end
    @(posedge clk) go <= 1'b0;
    repeat (5) @(posedge clk);
    apb(1'b0, ADDR_STAT, 32'h0, {1'b0, st});
    repeat (16) @(posedge clk);
  endtask : burst
  always @(posedge clk)
    if (psel && penable && pready)
      chk({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, ADDR_CFG, 32'h0, {1'b0, 32'h500});
    apb(1'b0, ADDR_STAT, 32'h0, 33'h0);
    apb(1'b1, 8'h08, 32'hffff, {1'b1, 32'h0});
    apb(1'b1, ADDR_STAT, 32'hf, {1'b1, 32'h0});
    apb(1'b0, 8'h0c, 32'h0, {1'b1, 32'h0});
    apb(1'b1, ADDR_CFG, 32'h512, 33'h0);
    apb(1'b0, ADDR_CFG, 32'h0, {1'b0, 32'h512});
    repeat (6) begin
      w = 1'($random(seed));
      b = 1'($random(seed));
      burst(w, b, 1'b0, {28'h0, 2'b10, w, 1'b1});
    end
    apb(1'b1, ADDR_CFG, 32'h502, 33'h0);
    burst(1'b1, 1'b0, 1'b0, 32'h1);
    self_refresh <= 1'b1;
    burst(1'b0, 1'b0, 1'b0, 32'h0);
    self_refresh <= 1'b0;
    banks_idle <= 1'b1;
    burst(1'b0, 1'b0, 1'b1, 32'h5);
    print_verdict();
  end
endmodule : test_dram_dynamic_async_odt
`default_nettype wire
